// ===== common/bpc_pkg.sv
package bpc_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned SLOTS    = 8;
  localparam int unsigned CMP_W    = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned IRQ_W    = 2;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_SLOT_BASE = 8'h00;  // Low byte at base+2x, high at base+2x+1
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h0F;
  localparam logic [7:0] ADDR_CMP_BASE  = 8'h20;  // Compare stage, read only
  localparam logic [7:0] ADDR_CMP_LAST  = 8'h2F;
  localparam logic [7:0] ADDR_SEL       = 8'h10;
  localparam logic [7:0] ADDR_EN        = 8'h11;
  localparam logic [7:0] ADDR_CTCTL     = 8'h12;
  localparam logic [7:0] ADDR_P4LATCH   = 8'h13;
  localparam logic [7:0] ADDR_IRQ_STS   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h15;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h16;

  // ---------------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned CTCTL_OVF_BIT = 0;
  localparam int unsigned IRQ_OVF_BIT   = 0;
  localparam int unsigned IRQ_LOAD_BIT  = 1;
  localparam logic [7:0]  RST_SEL       = 8'h00;
  localparam logic [7:0]  RST_EN        = 8'h00;
  localparam logic [7:0]  RST_P4LATCH   = 8'hFF;
  localparam logic [7:0]  RD_ZERO       = 8'h00;
  localparam logic [15:0] RST_CMP       = 16'h0000;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bpc_bus_req_t;

  typedef struct packed {
    logic [CMP_W-1:0] ct_count;
    logic             ct_ovf;
    logic [CMP_W-1:0] t2_count;
  } bpc_timebase_t;

endpackage : bpc_pkg

// ===== rtl/bpc_compare_unit.sv
`timescale 1ns/1ps

module bpc_compare_unit #(
  parameter int unsigned SLOTS = bpc_pkg::SLOTS
) (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  input  wire bpc_pkg::bpc_bus_req_t       i_bus,
  input  wire bpc_pkg::bpc_timebase_t      i_tb,
  output logic [bpc_pkg::BYTE_W-1:0]       o_rdata,
  output logic [SLOTS-1:0]                 o_port4,
  output logic                             o_irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [SLOTS-1:0][bpc_pkg::BYTE_W-1:0] reg_lo;
    logic [SLOTS-1:0][bpc_pkg::BYTE_W-1:0] reg_hi;
    logic [SLOTS-1:0][bpc_pkg::CMP_W-1:0]  cmp;
    logic [SLOTS-1:0]                      arm;
    logic [SLOTS-1:0]                      sel;
    logic [SLOTS-1:0]                      en;
    logic [SLOTS-1:0]                      p4latch;
    logic [SLOTS-1:0]                      out;
    logic                                  ovf_flag;
    logic [bpc_pkg::IRQ_W-1:0]             irq_sts;
    logic [bpc_pkg::IRQ_W-1:0]             irq_en;
    logic [bpc_pkg::BYTE_W-1:0]            rdata;
    logic                                  irq;
  } bpc_state_t;

  bpc_state_t st;
  bpc_state_t next_st;

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic bpc_in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    bpc_in_range = (a >= lo) && (a <= hi);
  endfunction : bpc_in_range

  function automatic logic [2:0] bpc_slot_of(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    bpc_slot_of = d[3:1];
  endfunction : bpc_slot_of

  function automatic logic [7:0] bpc_pad(input logic [SLOTS-1:0] v);
    logic [7:0] r;
    r = bpc_pkg::RD_ZERO;
    r[SLOTS-1:0] = v;
    bpc_pad = r;
  endfunction : bpc_pad

  logic             slot_hit;
  logic             slot_is_hi;
  logic [2:0]       slot_idx;
  logic [SLOTS-1:0] lo_wr;
  logic [SLOTS-1:0] hi_wr;
  logic [SLOTS-1:0] ct_match;
  logic [SLOTS-1:0] t2_match;
  logic             any_load;

  always_comb begin
    slot_hit   = bpc_in_range(i_bus.addr, bpc_pkg::ADDR_SLOT_BASE, bpc_pkg::ADDR_SLOT_LAST);
    slot_idx   = bpc_slot_of(i_bus.addr, bpc_pkg::ADDR_SLOT_BASE);
    slot_is_hi = i_bus.addr[0];
    lo_wr      = '0;
    hi_wr      = '0;
    if (i_bus.wr && slot_hit) begin
      if (slot_is_hi) begin
        hi_wr[slot_idx] = 1'b1;
      end else begin
        lo_wr[slot_idx] = 1'b1;
      end
    end
    for (int i = 0; i < SLOTS; i++) begin
      ct_match[i] = (i_tb.ct_count == st.cmp[i]);
      t2_match[i] = (i_tb.t2_count == st.cmp[i]);
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st  = st;
    any_load = 1'b0;

    // Register writes reach the register stage; a timer 2 low-byte write also reaches the compare stage below
    for (int i = 0; i < SLOTS; i++) begin
      if (lo_wr[i]) begin
        next_st.reg_lo[i] = i_bus.wdata;
      end
      if (hi_wr[i]) begin
        next_st.reg_hi[i] = i_bus.wdata;
      end
    end
    if (i_bus.wr) begin
      case (i_bus.addr)
        bpc_pkg::ADDR_SEL:      next_st.sel     = i_bus.wdata[SLOTS-1:0];
        bpc_pkg::ADDR_EN:       next_st.en      = i_bus.wdata[SLOTS-1:0];
        bpc_pkg::ADDR_P4LATCH:  next_st.p4latch = i_bus.wdata[SLOTS-1:0];
        bpc_pkg::ADDR_IRQ_EN:   next_st.irq_en  = i_bus.wdata[bpc_pkg::IRQ_W-1:0];
        bpc_pkg::ADDR_CTCTL:    next_st.ovf_flag = i_bus.wdata[bpc_pkg::CTCTL_OVF_BIT];
        bpc_pkg::ADDR_IRQ_CLR:  next_st.irq_sts = st.irq_sts & ~i_bus.wdata[bpc_pkg::IRQ_W-1:0];
        default:                next_st.sel     = next_st.sel;
      endcase
    end

    // Compare stage loading per slot
    for (int i = 0; i < SLOTS; i++) begin
      if (st.sel[i]) begin
        // Compare timer: load only on overflow, only when armed
        // Low write racing the overflow keeps the arm, so the
        // fresh low byte goes out whole at the next period
        if (i_tb.ct_ovf && st.arm[i] && !lo_wr[i]) begin
          next_st.cmp[i] = {st.reg_hi[i], st.reg_lo[i]};
          next_st.arm[i] = 1'b0;
          any_load       = 1'b1;
        end
        if (lo_wr[i]) begin
          next_st.arm[i] = 1'b1;
        end
      end else begin
        // Timer 2: low-byte write slips straight into the compare stage
        next_st.arm[i] = 1'b0;
        if (lo_wr[i]) begin
          next_st.cmp[i] = {st.reg_hi[i], i_bus.wdata};
        end
      end
    end

    // Shared overflow flag; set beats a software clear
    if (i_tb.ct_ovf) begin
      next_st.ovf_flag = 1'b1;
    end

    // Output lines
    for (int i = 0; i < SLOTS; i++) begin
      if (!st.en[i]) begin
        next_st.out[i] = st.p4latch[i];
      end else if (st.sel[i]) begin
        if (i_tb.ct_ovf) begin
          next_st.out[i] = 1'b0;
        end else if (ct_match[i]) begin
          next_st.out[i] = 1'b1;
        end
      end else if (t2_match[i]) begin
        next_st.out[i] = st.p4latch[i];
      end
    end

    // Sticky status, set wins over clear
    if (i_tb.ct_ovf) begin
      next_st.irq_sts[bpc_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (any_load) begin
      next_st.irq_sts[bpc_pkg::IRQ_LOAD_BIT] = 1'b1;
    end
    next_st.irq = |(next_st.irq_sts & next_st.irq_en);

    // Read data stands only in the cycle after the strobe
    next_st.rdata = bpc_pkg::RD_ZERO;
    if (i_bus.rd) begin
      if (slot_hit) begin
        next_st.rdata = slot_is_hi ? st.reg_hi[slot_idx] : st.reg_lo[slot_idx];
      end else if (bpc_in_range(i_bus.addr, bpc_pkg::ADDR_CMP_BASE, bpc_pkg::ADDR_CMP_LAST)) begin
        next_st.rdata = i_bus.addr[0]
                      ? st.cmp[bpc_slot_of(i_bus.addr, bpc_pkg::ADDR_CMP_BASE)][15:8]
                      : st.cmp[bpc_slot_of(i_bus.addr, bpc_pkg::ADDR_CMP_BASE)][7:0];
      end else begin
        case (i_bus.addr)
          bpc_pkg::ADDR_SEL:     next_st.rdata = bpc_pad(st.sel);
          bpc_pkg::ADDR_EN:      next_st.rdata = bpc_pad(st.en);
          bpc_pkg::ADDR_P4LATCH: next_st.rdata = bpc_pad(st.p4latch);
          bpc_pkg::ADDR_CTCTL: begin
            next_st.rdata = bpc_pkg::RD_ZERO;
            next_st.rdata[bpc_pkg::CTCTL_OVF_BIT] = st.ovf_flag;
          end
          bpc_pkg::ADDR_IRQ_STS: next_st.rdata = {6'h00, st.irq_sts};
          bpc_pkg::ADDR_IRQ_EN:  next_st.rdata = {6'h00, st.irq_en};
          default:               next_st.rdata = bpc_pkg::RD_ZERO;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st.reg_lo   <= '0;
      st.reg_hi   <= '0;
      st.cmp      <= {SLOTS{bpc_pkg::RST_CMP}};
      st.arm      <= '0;
      st.sel      <= bpc_pkg::RST_SEL[SLOTS-1:0];
      st.en       <= bpc_pkg::RST_EN[SLOTS-1:0];
      st.p4latch  <= bpc_pkg::RST_P4LATCH[SLOTS-1:0];
      st.out      <= bpc_pkg::RST_P4LATCH[SLOTS-1:0];
      st.ovf_flag <= 1'b0;
      st.irq_sts  <= '0;
      st.irq_en   <= '0;
      st.rdata    <= bpc_pkg::RD_ZERO;
      st.irq      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_port4 = st.out;
  assign o_irq   = st.irq;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking bpc_cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_ovf_sets_flag: assert property (i_tb.ct_ovf |=> st.ovf_flag)
    else $error("overflow did not set the flag");

  chk_irq_follows: assert property (##1 (o_irq == |($past(next_st.irq_sts) & $past(next_st.irq_en))))
    else $error("interrupt output does not follow status and enable");

  chk_irq_level: assert property (o_irq == |(st.irq_sts & st.irq_en))
    else $error("interrupt output does not match enabled status");

  chk_sts_sets: assert property (i_tb.ct_ovf |=> st.irq_sts[bpc_pkg::IRQ_OVF_BIT])
    else $error("overflow did not set its status bit");

  chk_flag_sticky: assert property (
    (st.ovf_flag && !(i_bus.wr && (i_bus.addr == bpc_pkg::ADDR_CTCTL))) |=> st.ovf_flag)
    else $error("overflow flag dropped without a write");

  chk_sel_after_reset: assert property ($rose(i_rst_n) |-> (st.sel == '0) && (st.en == '0))
    else $error("select or enable not zero after reset");

  chk_sel_write: assert property (
    (i_bus.wr && (i_bus.addr == bpc_pkg::ADDR_SEL)) |=> (st.sel == $past(i_bus.wdata[SLOTS-1:0])))
    else $error("select register did not take the write");

  chk_en_write: assert property (
    (i_bus.wr && (i_bus.addr == bpc_pkg::ADDR_EN)) |=> (st.en == $past(i_bus.wdata[SLOTS-1:0])))
    else $error("enable register did not take the write");

  chk_rdata_idle: assert property (!i_bus.rd |=> (o_rdata == bpc_pkg::RD_ZERO))
    else $error("read data did not return to zero");

  // ---------------------------------------------------------------------------
  // Per-slot checks
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < SLOTS; g++) begin : g_chk
    chk_ovf_full_load: assert property (
      (st.sel[g] && st.arm[g] && i_tb.ct_ovf && !lo_wr[g])
      |=> (st.cmp[g] == $past({st.reg_hi[g], st.reg_lo[g]})) && !st.arm[g])
      else $error("armed overflow did not load the full value");

    chk_no_load_unarmed: assert property (
      (st.sel[g] && !st.arm[g] && !lo_wr[g]) |=> $stable(st.cmp[g]))
      else $error("compare stage changed without an armed overflow");

    chk_hi_write_holds: assert property (
      (st.sel[g] && hi_wr[g] && !st.arm[g]) |=> !st.arm[g] ##0 $stable(st.cmp[g]))
      else $error("high byte write disturbed the compare stage");

    chk_lo_write_arms: assert property (
      (st.sel[g] && lo_wr[g]) |=> st.arm[g] && $stable(st.cmp[g]))
      else $error("low byte write did not arm or loaded early");

    chk_arm_holds: assert property (
      (st.sel[g] && st.arm[g] && !i_tb.ct_ovf) |=> st.arm[g])
      else $error("armed transfer dropped before an overflow");

    chk_direct_load: assert property (
      (!st.sel[g] && lo_wr[g]) |=> st.cmp[g] == {$past(st.reg_hi[g]), $past(i_bus.wdata)})
      else $error("timer 2 slot did not load on low byte write");

    chk_t2_no_arm: assert property (
      !st.sel[g] |=> !st.arm[g])
      else $error("timer 2 slot left an armed transfer");

    chk_t2_ovf_ignored: assert property (
      (!st.sel[g] && !lo_wr[g]) |=> $stable(st.cmp[g]))
      else $error("timer 2 slot compare stage changed without a low write");

    chk_lo_reg_write: assert property (
      lo_wr[g] |=> st.reg_lo[g] == $past(i_bus.wdata))
      else $error("low byte register did not take the write");

    chk_hi_reg_write: assert property (
      hi_wr[g] |=> st.reg_hi[g] == $past(i_bus.wdata))
      else $error("high byte register did not take the write");

    chk_pwm_low: assert property (
      (st.en[g] && st.sel[g] && i_tb.ct_ovf) |=> !o_port4[g])
      else $error("pwm output not low after overflow");

    chk_pwm_high: assert property (
      (st.en[g] && st.sel[g] && !i_tb.ct_ovf && ct_match[g]) |=> o_port4[g])
      else $error("pwm output not high after match");

    chk_pwm_hold: assert property (
      (st.en[g] && st.sel[g] && !i_tb.ct_ovf && !ct_match[g]) |=> $stable(o_port4[g]))
      else $error("pwm output moved without match or overflow");

    chk_mode1_match: assert property (
      (st.en[g] && !st.sel[g] && t2_match[g]) |=> o_port4[g] == $past(st.p4latch[g]))
      else $error("timer 2 match did not pass the latch value");

    chk_mode1_hold: assert property (
      (st.en[g] && !st.sel[g] && !t2_match[g]) |=> $stable(o_port4[g]))
      else $error("timer 2 slot pin moved without a match");

    chk_disabled_pin: assert property (
      !st.en[g] |=> o_port4[g] == $past(st.p4latch[g]))
      else $error("disabled slot pin does not follow the latch");
  end

  cov_ovf_load:    cover property (st.sel[0] && st.arm[0] && i_tb.ct_ovf ##1 !st.arm[0]);
  cov_hi_then_ovf: cover property (st.sel[0] && hi_wr[0] ##[1:20] i_tb.ct_ovf);
  cov_direct_load: cover property (!st.sel[0] && lo_wr[0]);
  cov_pwm_cycle:   cover property (st.en[0] && st.sel[0] && ct_match[0] ##[1:50] i_tb.ct_ovf);
  cov_mode1_match: cover property (st.en[1] && !st.sel[1] && t2_match[1]);

endmodule : bpc_compare_unit

// ===== tb/bpc_compare_unit_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error %s expected %0h seen %0h", nm, e, g); end end

module bpc_compare_unit_tb;
  logic                         i_mclk;
  logic                         i_rst_n;
  bpc_pkg::bpc_bus_req_t        bus;
  bpc_pkg::bpc_timebase_t       tbv;
  logic [bpc_pkg::BYTE_W-1:0]   o_rdata;
  logic [bpc_pkg::SLOTS-1:0]    o_port4;
  logic                         o_irq;
  int                           error_cnt;
  int                           total_checks;
  logic [15:0]                  val;
  logic [15:0]                  got;
  logic [15:0]                  cmp0;
  logic [15:0]                  nxt;
  logic [7:0]                   d;

  bpc_compare_unit #(.SLOTS(bpc_pkg::SLOTS)) dut (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_bus   (bus),
    .i_tb    (tbv),
    .o_rdata (o_rdata),
    .o_port4 (o_port4),
    .o_irq   (o_irq)
  );

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // ---------------------------------------------------------------------------
  // Bus and timer tasks
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus <= '0;
    #1 v = o_rdata;
  endtask : rd

  task automatic wr_slot(input int s, input logic [15:0] v);
    wr(8'(2 * s + 1), v[15:8]);
    wr(8'(2 * s), v[7:0]);
  endtask : wr_slot

  task automatic rd_cmp(input int s, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(bpc_pkg::ADDR_CMP_BASE + 8'(2 * s), lo);
    rd(bpc_pkg::ADDR_CMP_BASE + 8'(2 * s + 1), hi);
    v = {hi, lo};
  endtask : rd_cmp

  task automatic ovf();
    @(posedge i_mclk);
    tbv.ct_ovf <= 1'b1;
    @(posedge i_mclk);
    tbv.ct_ovf <= 1'b0;
    #1;
  endtask : ovf

  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : settle

  // Compare stage expected after an overflow
  function automatic logic [15:0] exp_after_ovf(input logic        armed,
                                                input logic [15:0] held,
                                                input logic [15:0] staged);
    exp_after_ovf = armed ? staged : held;
  endfunction : exp_after_ovf

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------------
  // Hang guard
  // ---------------------------------------------------------------------------
  initial begin
    #200000;
    $display("Error watchdog expected 0 seen 1");
    error_cnt++;
    final_report();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    total_checks = 0;
    i_rst_n = 1'b0;
    bus = '0;
    tbv = '0;
    val = 16'($urandom(32'h64a4e2a1));
    repeat (3) @(posedge i_mclk);
    #1 `CHK("port4 in reset", 8'hFF, o_port4)
    `CHK("irq in reset", 1'b0, o_irq)
    i_rst_n <= 1'b1;
    rd(bpc_pkg::ADDR_SEL, d);
    `CHK("select reset", 8'h00, d)
    rd(bpc_pkg::ADDR_EN, d);
    `CHK("enable reset", 8'h00, d)
    rd_cmp(3, got);
    `CHK("compare stage reset", 16'h0000, got)
    rd(8'h30, d);
    `CHK("unmapped read", 8'h00, d)
    $display("test reset done");

    // Timer 2 slots load directly on low-byte write
    for (int s = 0; s < bpc_pkg::SLOTS; s++) begin
      val = 16'($urandom()) | 16'h8000;
      wr_slot(s, val);
      rd_cmp(s, got);
      `CHK("direct load", val, got)
      if (s == 0) cmp0 = val;
    end
    wr(bpc_pkg::ADDR_CMP_BASE, 8'h00);
    rd_cmp(0, got);
    `CHK("compare stage read only", cmp0, got)
    $display("test direct load done");

    // Mode 1 pin takes latch bit on timer 2 match
    wr_slot(1, 16'h1234);
    wr(bpc_pkg::ADDR_EN, 8'h02);
    tbv.t2_count <= 16'h1234;
    settle(2);
    `CHK("mode1 match high", 8'hFF, o_port4)
    tbv.t2_count <= 16'h0000;
    wr(bpc_pkg::ADDR_P4LATCH, 8'h00);
    settle(2);
    `CHK("mode1 hold", 8'h02, o_port4)
    tbv.t2_count <= 16'h1234;
    settle(2);
    `CHK("mode1 match low", 8'h00, o_port4)
    tbv.t2_count <= 16'h0000;
    $display("test mode1 done");

    // Compare timer slot: buffered loading at overflow
    wr(bpc_pkg::ADDR_SEL, 8'h01);
    val = 16'($urandom()) | 16'h8000;
    wr(8'h01, val[15:8]);
    ovf();
    rd_cmp(0, got);
    `CHK("high only no load", exp_after_ovf(1'b0, cmp0, val), got)
    rd(bpc_pkg::ADDR_CTCTL, d);
    `CHK("overflow flag", 1'b1, d[0])
    wr(bpc_pkg::ADDR_CTCTL, 8'h00);
    rd(bpc_pkg::ADDR_CTCTL, d);
    `CHK("overflow flag clear", 1'b0, d[0])
    wr(8'h00, val[7:0]);
    rd_cmp(0, got);
    `CHK("no load before overflow", cmp0, got)
    ovf();
    rd_cmp(0, got);
    `CHK("load at overflow", exp_after_ovf(1'b1, cmp0, val), got)
    wr(8'h01, ~val[15:8]);
    ovf();
    rd_cmp(0, got);
    `CHK("unarmed overflow", exp_after_ovf(1'b0, val, {~val[15:8], val[7:0]}), got)
    $display("test buffered load done");

    // Mode 0 waveform
    wr(bpc_pkg::ADDR_EN, 8'h03);
    tbv.ct_count <= val;
    settle(2);
    `CHK("mode0 match", 1'b1, o_port4[0])
    tbv.ct_count <= 16'h0000;
    ovf();
    `CHK("mode0 overflow low", 1'b0, o_port4[0])
    tbv.t2_count <= val;
    settle(2);
    `CHK("mode0 ignores timer 2", 1'b0, o_port4[0])
    tbv.t2_count <= 16'h0000;
    $display("test pwm done");

    // Shared overflow interrupt
    wr(bpc_pkg::ADDR_IRQ_EN, 8'h01);
    settle(2);
    `CHK("irq raised", 1'b1, o_irq)
    wr(bpc_pkg::ADDR_IRQ_EN, 8'h00);
    settle(2);
    `CHK("irq masked", 1'b0, o_irq)
    wr(bpc_pkg::ADDR_IRQ_EN, 8'h01);
    wr(bpc_pkg::ADDR_IRQ_CLR, 8'h01);
    settle(2);
    `CHK("irq cleared", 1'b0, o_irq)
    rd(bpc_pkg::ADDR_IRQ_STS, d);
    `CHK("status cleared", 1'b0, d[0])
    `CHK("load status", 1'b1, d[1])
    $display("test irq done");

    // Preload both stages, then change the low byte alone
    val = 16'($urandom());
    nxt = ~val;
    wr_slot(2, val);
    wr(bpc_pkg::ADDR_SEL, 8'h05);
    wr_slot(2, nxt);
    wr(bpc_pkg::ADDR_EN, 8'h07);
    rd_cmp(2, got);
    `CHK("preload first period", val, got)
    ovf();
    rd_cmp(2, got);
    `CHK("preload second period", exp_after_ovf(1'b1, val, nxt), got)
    d = ~nxt[7:0];
    wr(8'h04, d);
    ovf();
    rd_cmp(2, got);
    `CHK("low byte alone", exp_after_ovf(1'b1, nxt, {nxt[15:8], d}), got)
    $display("test preload done");
    final_report();
  end
endmodule : bpc_compare_unit_tb
